// ---- logic/origin_shift_map.svh ----
// register offsets, field positions, reset values and limits
`ifndef ORIGIN_SHIFT_MAP_SVH
`define ORIGIN_SHIFT_MAP_SVH

`define AX_SHIFT_DIST     6'h00
`define AX_CFG            6'h04
`define AX_HOMING_SPEED   6'h08
`define AX_CREEP_SPEED    6'h0c
`define AX_BACKLASH       6'h10
`define AX_GEAR           6'h14
`define AX_UNIT_MULT      6'h18
`define AX_STATUS_WORD    6'h1c
`define AX_CUR_FEED       6'h20
`define AX_MACH_FEED      6'h24
`define AX_OP_STATUS      6'h28
`define AX_TRAVEL_DOG     6'h2c
`define AX_ERR_CODE       6'h30
`define AX_BL_PULSES      6'h34
`define AX_HOMING_REQ     6'h38
`define GLOBAL_CTRL       12'h100

`define CFG_SPEED_SEL_BIT 0
`define CFG_METHOD_LSB    4
`define CFG_STEPPER_BIT   8
`define ST_BL_ERR_BIT     0
`define ST_REQ_BIT        3
`define ST_DONE_BIT       4

`define RST_SHIFT_DIST    32'h0000_0000
`define RST_SPEED_SEL     1'b0
`define RST_BACKLASH      16'h0000
`define RST_SPEED         16'h0010
`define RST_GEAR_AP       16'h0001
`define RST_GEAR_AL       16'h0001

`define BL_MAX_PULSES     32'h0000_00ff
`define ERR_BL_AMOUNT     16'd920
`define HOME_ADDRESS      32'h0000_0000
`define MIN_PULSE_PERIOD  16'h0002

`endif

// ---- logic/origin_shift_pkg.sv ----
// types shared by the positioning add-on block
package origin_shift_pkg;
  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_RUN   = 2'b01,
    HS_SHIFT = 2'b11,
    HS_DONE  = 2'b10
  } home_state_t;

  typedef enum logic [3:0] {
    OP_STANDBY = 4'h0,
    OP_HOMING  = 4'h1,
    OP_SHIFT   = 4'h2
  } op_status_t;

  typedef enum logic [1:0] {
    UNIT_X1    = 2'h0,
    UNIT_X10   = 2'h1,
    UNIT_X100  = 2'h2,
    UNIT_X1000 = 2'h3
  } unit_mult_t;
endpackage

// ---- logic/pulse_rate.sv ----
// enable-pulse divider that paces shift pulses
`timescale 1ns/1ps
`include "origin_shift_map.svh"
module pulse_rate import origin_shift_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic [15:0] period,
  // tick out
  output logic tick
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic next_tick;
  logic [15:0] lim;

  always_comb begin
    // output pulse needs a low phase, so never faster than every 2nd cycle
    lim = (period < `MIN_PULSE_PERIOD) ? `MIN_PULSE_PERIOD : period;
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = 16'h0000;
    end else if (cnt >= lim - 16'h0001) begin
      next_cnt = 16'h0000;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// ---- logic/gear_div.sv ----
// sequential restoring divider, floor quotient
`timescale 1ns/1ps
module gear_div import origin_shift_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request
  input wire logic start,
  input wire logic [31:0] num,
  input wire logic [31:0] den,
  // result
  output logic done,
  output logic [31:0] quot
);
  logic [31:0] rem;
  logic [31:0] q;
  logic [31:0] d;
  logic [5:0] cnt;
  logic busy;
  logic [31:0] next_rem;
  logic [31:0] next_q;
  logic [31:0] next_d;
  logic [5:0] next_cnt;
  logic next_busy;
  logic next_done;
  logic [31:0] next_quot;
  logic [32:0] trial;

  always_comb begin
    next_rem = rem;
    next_q = q;
    next_d = d;
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    next_quot = quot;
    trial = {rem, q[31]} - {1'b0, d};
    if (start) begin
      next_rem = 32'h0000_0000;
      next_q = num;
      next_d = den;
      next_cnt = 6'h20;
      next_busy = 1'b1;
    end else if (busy) begin
      // fraction is simply dropped: floor division
      if (!trial[32]) begin
        next_rem = trial[31:0];
        next_q = {q[30:0], 1'b1};
      end else begin
        next_rem = {rem[30:0], q[31]};
        next_q = {q[30:0], 1'b0};
      end
      next_cnt = cnt - 6'h01;
      if (cnt == 6'h01) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        // zero divisor gives all ones, which trips the limit check
        next_quot = (d == 32'h0000_0000) ? 32'hffff_ffff : next_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem <= 32'h0000_0000;
      q <= 32'h0000_0000;
      d <= 32'h0000_0000;
      cnt <= 6'h00;
      busy <= 1'b0;
      done <= 1'b0;
      quot <= 32'h0000_0000;
    end else begin
      rem <= next_rem;
      q <= next_q;
      d <= next_d;
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
      quot <= next_quot;
    end
  end
endmodule

// ---- logic/origin_shift_backlash_comp.sv ----
// home shift and backlash compensation for two axes, APB registers
//
// How it works
// R1: after zero signal, move further by shift distance; stop point is home
// R2: shift works with every homing method
// R3: shift runs at homing speed when select is 0, creep speed when 1
// R4: home-complete bit b4, feed values, op status set only after shift
// R5: homing-request bit b3 cleared when shift completes
// R6: travel-after-dog counts from dog to shift start, excludes shift
// R7: stopper homing methods keep travel-after-dog at 0
// R8: software shifts opposite to homing direction for stopper methods
// R9: software keeps shift distance inside the limit switches
// R10: new shift and backlash settings load on controller-ready rising edge
// R11: shift distance, speed select and backlash reset to 0
// R12: every axis has its own parameter set
// R13: on each direction reversal emit backlash pulses extra
// R14: backlash pulses go out at the reversal, with the move pulses
// R15: backlash pulses never touch current or machine feed value
// R16: pulses per compensation is backlash over travel per pulse, floored
// R17: above 255 pulses raise backlash error, code 920
// R18: no backlash compensation for stepping motors
// R19: software runs a homing run before moving with nonzero backlash
// R20: travel per pulse is travel per rev times multiplier over pulses per rev
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "origin_shift_map.svh"
module origin_shift_backlash_comp import origin_shift_pkg::*; (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // homing engine events, one bit per axis
  input wire logic [1:0] homing_start,
  input wire logic [1:0] dog_on,
  input wire logic [1:0] zero_hit,
  // profile generator movement pulses
  input wire logic [1:0] move_pulse,
  input wire logic [1:0] move_dir,
  // command pulses to drive
  output logic [1:0] cmd_pulse,
  output logic [1:0] cmd_dir,
  output logic controller_ready_out
);
  logic controller_ready;
  logic ready_prev;
  logic next_controller_ready;
  logic ready_rise;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic wr_go;
  logic ax_hit;
  logic glob_hit;
  logic [5:0] off;
  logic [31:0] rd_word [2];
  logic rd_ok [2];

  assign off = paddr[5:0];
  assign ax_hit = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'b00);
  assign glob_hit = (paddr == `GLOBAL_CTRL);
  assign wr_go = psel && penable && pwrite && pready && !pslverr;
  assign ready_rise = controller_ready && !ready_prev;

  always_comb begin
    next_controller_ready = controller_ready;
    if (wr_go && glob_hit) begin
      next_controller_ready = pwdata[0];
    end
    // zero-wait slave: answer in the first access cycle
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !glob_hit &&
                   !(ax_hit && rd_ok[paddr[6]]);
    next_prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (glob_hit) begin
        next_prdata = {31'h0, controller_ready};
      end else if (ax_hit && rd_ok[paddr[6]]) begin
        next_prdata = rd_word[paddr[6]];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      controller_ready <= 1'b0;
      ready_prev <= 1'b0;
      controller_ready_out <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      controller_ready <= next_controller_ready;
      ready_prev <= controller_ready;
      controller_ready_out <= next_controller_ready;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : axis
    // staged copy written by software, active copy used by hardware
    logic [31:0] s_dist;
    logic s_sel;
    logic [2:0] s_meth;
    logic s_step;
    logic [15:0] s_hspd;
    logic [15:0] s_cspd;
    logic [15:0] s_bl;
    logic [15:0] s_ap;
    logic [15:0] s_al;
    unit_mult_t s_am;
    logic [31:0] a_dist;
    logic a_sel;
    logic [2:0] a_meth;
    logic a_step;
    logic [15:0] a_hspd;
    logic [15:0] a_cspd;
    logic [15:0] a_bl;
    logic [31:0] next_s_dist;
    logic next_s_sel;
    logic [2:0] next_s_meth;
    logic next_s_step;
    logic [15:0] next_s_hspd;
    logic [15:0] next_s_cspd;
    logic [15:0] next_s_bl;
    logic [15:0] next_s_ap;
    logic [15:0] next_s_al;
    unit_mult_t next_s_am;
    // run-time state
    home_state_t st;
    home_state_t next_st;
    op_status_t op;
    op_status_t next_op;
    logic req;
    logic cmpl;
    logic bl_err;
    logic [15:0] err_code;
    logic [31:0] bl_pulses;
    logic [31:0] cur_feed;
    logic [31:0] mach_feed;
    logic [31:0] tad;
    logic dog_seen;
    logic [31:0] shift_left;
    logic last_dir;
    logic dir_known;
    logic [7:0] burst;
    logic [7:0] pend;
    logic pend_dir;
    logic next_req;
    logic next_cmpl;
    logic next_bl_err;
    logic [15:0] next_err_code;
    logic [31:0] next_bl_pulses;
    logic [31:0] next_cur_feed;
    logic [31:0] next_mach_feed;
    logic [31:0] next_tad;
    logic next_dog_seen;
    logic [31:0] next_shift_left;
    logic next_last_dir;
    logic next_dir_known;
    logic [7:0] next_burst;
    logic [7:0] next_pend;
    logic next_pend_dir;
    logic next_pulse;
    logic next_dir;
    logic stopper;
    logic wr_me;
    logic div_done;
    logic [31:0] div_q;
    logic [31:0] den;
    logic [31:0] num;
    logic tick;
    logic [31:0] step;

    assign wr_me = wr_go && ax_hit && (paddr[6] == 1'(g));
    assign stopper = (a_meth >= 3'h1) && (a_meth <= 3'h3);
    assign num = s_bl * s_ap;
    always_comb begin
      unique case (s_am)
        UNIT_X1: den = {16'h0, s_al};
        UNIT_X10: den = s_al * 32'd10;
        UNIT_X100: den = s_al * 32'd100;
        UNIT_X1000: den = s_al * 32'd1000;
      endcase
    end

    // pulses = backlash * pulses_per_rev / (travel_per_rev * mult)
    gear_div u_div ( // R16 R20
      .pclk(pclk),
      .presetn(presetn),
      .start(ready_rise),
      .num(num),
      .den(den),
      .done(div_done),
      .quot(div_q)
    );

    pulse_rate u_rate (
      .pclk(pclk),
      .presetn(presetn),
      .run(st == HS_SHIFT),
      .period(a_sel ? a_cspd : a_hspd), // R3
      .tick(tick)
    );

    always_comb begin
      next_s_dist = s_dist;
      next_s_sel = s_sel;
      next_s_meth = s_meth;
      next_s_step = s_step;
      next_s_hspd = s_hspd;
      next_s_cspd = s_cspd;
      next_s_bl = s_bl;
      next_s_ap = s_ap;
      next_s_al = s_al;
      next_s_am = s_am;
      if (wr_me) begin
        unique case (off)
          `AX_SHIFT_DIST: next_s_dist = pwdata;
          `AX_CFG: begin
            next_s_sel = pwdata[`CFG_SPEED_SEL_BIT];
            next_s_meth = pwdata[`CFG_METHOD_LSB +: 3];
            next_s_step = pwdata[`CFG_STEPPER_BIT];
          end
          `AX_HOMING_SPEED: next_s_hspd = pwdata[15:0];
          `AX_CREEP_SPEED: next_s_cspd = pwdata[15:0];
          `AX_BACKLASH: next_s_bl = pwdata[15:0];
          `AX_GEAR: begin
            next_s_ap = pwdata[15:0];
            next_s_al = pwdata[31:16];
          end
          `AX_UNIT_MULT: next_s_am = unit_mult_t'(pwdata[1:0]);
          default: begin
          end
        endcase
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s_dist <= `RST_SHIFT_DIST; // R11
        s_sel <= `RST_SPEED_SEL; // R11
        s_meth <= 3'h0;
        s_step <= 1'b0;
        s_hspd <= `RST_SPEED;
        s_cspd <= `RST_SPEED;
        s_bl <= `RST_BACKLASH; // R11
        s_ap <= `RST_GEAR_AP;
        s_al <= `RST_GEAR_AL;
        s_am <= UNIT_X1;
        a_dist <= `RST_SHIFT_DIST;
        a_sel <= `RST_SPEED_SEL;
        a_meth <= 3'h0;
        a_step <= 1'b0;
        a_hspd <= `RST_SPEED;
        a_cspd <= `RST_SPEED;
        a_bl <= `RST_BACKLASH;
      end else begin
        s_dist <= next_s_dist;
        s_sel <= next_s_sel;
        s_meth <= next_s_meth;
        s_step <= next_s_step;
        s_hspd <= next_s_hspd;
        s_cspd <= next_s_cspd;
        s_bl <= next_s_bl;
        s_ap <= next_s_ap;
        s_al <= next_s_al;
        s_am <= next_s_am;
        if (ready_rise) begin // R10 R12
          a_dist <= s_dist;
          a_sel <= s_sel;
          a_meth <= s_meth;
          a_step <= s_step;
          a_hspd <= s_hspd;
          a_cspd <= s_cspd;
          a_bl <= s_bl;
        end
      end
    end

    always_comb begin
      next_st = st;
      next_op = op;
      next_req = req;
      next_cmpl = cmpl;
      next_bl_err = bl_err;
      next_err_code = err_code;
      next_bl_pulses = bl_pulses;
      next_cur_feed = cur_feed;
      next_mach_feed = mach_feed;
      next_tad = tad;
      next_dog_seen = dog_seen;
      next_shift_left = shift_left;
      next_last_dir = last_dir;
      next_dir_known = dir_known;
      next_burst = burst;
      next_pend = pend;
      next_pend_dir = pend_dir;
      next_pulse = 1'b0;
      next_dir = cmd_dir[g];
      step = move_dir[g] ? 32'hffff_ffff : 32'h0000_0001;
      if (ready_rise) begin
        next_bl_pulses = 32'h0000_0000;
      end
      if (div_done) begin
        if (div_q > `BL_MAX_PULSES) begin // R17
          next_bl_err = 1'b1;
          next_err_code = `ERR_BL_AMOUNT;
          next_bl_pulses = 32'h0000_0000;
        end else begin
          next_bl_err = 1'b0;
          next_err_code = 16'h0000;
          next_bl_pulses = (a_bl == 16'h0000) ? 32'h0 : div_q;
        end
      end
      // movement pulses: feed counts at intake, backlash never counted
      if (move_pulse[g]) begin
        next_cur_feed = cur_feed + step; // R15
        next_mach_feed = mach_feed + step; // R15
        if (st == HS_RUN && dog_seen && !stopper) begin
          next_tad = tad + 32'h0000_0001; // R6 R7
        end
        if (dir_known && move_dir[g] != last_dir && !a_step && // R18
            !bl_err && bl_pulses != 32'h0) begin
          next_burst = bl_pulses[7:0]; // R13
        end
        next_pend = pend + 8'h01;
        next_pend_dir = move_dir[g];
        next_last_dir = move_dir[g];
        next_dir_known = 1'b1;
      end
      // emit: backlash first, right at the reversal, then held moves
      if (!cmd_pulse[g]) begin
        if (next_burst != 8'h00) begin
          next_burst = next_burst - 8'h01; // R14
          next_pulse = 1'b1;
          next_dir = next_pend_dir;
        end else if (next_pend != 8'h00) begin
          next_pend = next_pend - 8'h01; // R14
          next_pulse = 1'b1;
          next_dir = next_pend_dir;
        end else if (st == HS_SHIFT && tick && shift_left != 32'h0) begin
          next_shift_left = shift_left - 32'h0000_0001; // R1
          next_pulse = 1'b1;
          next_dir = a_dist[31];
        end
      end
      if (wr_me && off == `AX_HOMING_REQ && pwdata[0]) begin
        next_req = 1'b1;
      end
      unique case (st)
        HS_IDLE: begin
          if (homing_start[g]) begin
            next_st = HS_RUN;
            next_op = OP_HOMING;
            next_cmpl = 1'b0;
            next_tad = 32'h0000_0000;
            next_dog_seen = 1'b0;
          end
        end
        HS_RUN: begin
          if (dog_on[g]) begin
            next_dog_seen = 1'b1;
          end
          // shift applies for any homing method
          if (zero_hit[g]) begin // R2
            if (a_dist == 32'h0000_0000) begin
              next_st = HS_DONE;
            end else begin
              next_st = HS_SHIFT; // R1
              next_op = OP_SHIFT;
              next_shift_left = a_dist[31] ? 32'h0 - a_dist : a_dist;
            end
          end
        end
        HS_SHIFT: begin
          if (next_shift_left == 32'h0000_0000) begin
            next_st = HS_DONE;
          end
        end
        HS_DONE: begin
          // stop point becomes home only now
          next_st = HS_IDLE;
          next_cmpl = 1'b1; // R4
          next_req = 1'b0; // R5
          next_cur_feed = `HOME_ADDRESS; // R4
          next_mach_feed = `HOME_ADDRESS; // R4
          next_op = OP_STANDBY; // R4
        end
      endcase
      if (stopper) begin
        next_tad = 32'h0000_0000; // R7
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st <= HS_IDLE;
        op <= OP_STANDBY;
        req <= 1'b1;
        cmpl <= 1'b0;
        bl_err <= 1'b0;
        err_code <= 16'h0000;
        bl_pulses <= 32'h0000_0000;
        cur_feed <= 32'h0000_0000;
        mach_feed <= 32'h0000_0000;
        tad <= 32'h0000_0000;
        dog_seen <= 1'b0;
        shift_left <= 32'h0000_0000;
        last_dir <= 1'b0;
        dir_known <= 1'b0;
        burst <= 8'h00;
        pend <= 8'h00;
        pend_dir <= 1'b0;
        cmd_pulse[g] <= 1'b0;
        cmd_dir[g] <= 1'b0;
      end else begin
        st <= next_st;
        op <= next_op;
        req <= next_req;
        cmpl <= next_cmpl;
        bl_err <= next_bl_err;
        err_code <= next_err_code;
        bl_pulses <= next_bl_pulses;
        cur_feed <= next_cur_feed;
        mach_feed <= next_mach_feed;
        tad <= next_tad;
        dog_seen <= next_dog_seen;
        shift_left <= next_shift_left;
        last_dir <= next_last_dir;
        dir_known <= next_dir_known;
        burst <= next_burst;
        pend <= next_pend;
        pend_dir <= next_pend_dir;
        cmd_pulse[g] <= next_pulse;
        cmd_dir[g] <= next_dir;
      end
    end

    always_comb begin
      rd_ok[g] = 1'b1;
      rd_word[g] = 32'h0000_0000;
      unique case (off)
        `AX_SHIFT_DIST: rd_word[g] = s_dist;
        `AX_CFG: begin
          rd_word[g][`CFG_SPEED_SEL_BIT] = s_sel;
          rd_word[g][`CFG_METHOD_LSB +: 3] = s_meth;
          rd_word[g][`CFG_STEPPER_BIT] = s_step;
        end
        `AX_HOMING_SPEED: rd_word[g] = {16'h0, s_hspd};
        `AX_CREEP_SPEED: rd_word[g] = {16'h0, s_cspd};
        `AX_BACKLASH: rd_word[g] = {16'h0, s_bl};
        `AX_GEAR: rd_word[g] = {s_al, s_ap};
        `AX_UNIT_MULT: rd_word[g] = {30'h0, s_am};
        `AX_STATUS_WORD: begin
          rd_word[g][`ST_BL_ERR_BIT] = bl_err;
          rd_word[g][`ST_REQ_BIT] = req;
          rd_word[g][`ST_DONE_BIT] = cmpl;
        end
        `AX_CUR_FEED: rd_word[g] = cur_feed;
        `AX_MACH_FEED: rd_word[g] = mach_feed;
        `AX_OP_STATUS: rd_word[g] = {28'h0, op};
        `AX_TRAVEL_DOG: rd_word[g] = tad;
        `AX_ERR_CODE: rd_word[g] = {16'h0, err_code};
        `AX_BL_PULSES: rd_word[g] = bl_pulses;
        `AX_HOMING_REQ: rd_word[g] = {31'h0, req};
        default: rd_ok[g] = 1'b0;
      endcase
    end
  end
endmodule

// ---- testbench/origin_shift_asserts.sv ----
// port checks for the home shift and backlash block
`timescale 1ns/1ps
`include "origin_shift_map.svh"
module origin_shift_asserts (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // axis events
  input wire logic [1:0] homing_start,
  input wire logic [1:0] dog_on,
  input wire logic [1:0] zero_hit,
  input wire logic [1:0] move_pulse,
  input wire logic [1:0] move_dir,
  // drive side
  input wire logic [1:0] cmd_pulse,
  input wire logic [1:0] cmd_dir,
  input wire logic controller_ready_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire ctrl_wr = psel && penable && pready && pwrite &&
                 paddr == `GLOBAL_CTRL;
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  ready_cause_a: assert property
    (pready |-> psel && penable && $past(psel && !penable))
    else $error("pready outside access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  pulse_gap0_a: assert property (cmd_pulse[0] |=> !cmd_pulse[0])
    else $error("axis0 pulses back to back");
  pulse_gap1_a: assert property (cmd_pulse[1] |=> !cmd_pulse[1])
    else $error("axis1 pulses back to back");
  ready_load_a: assert property (
    ctrl_wr |=> ##[0:1] controller_ready_out == $past(pwdata[0], 1))
    else $error("ready copy wrong");
  ready_hold_a: assert property (
    $changed(controller_ready_out) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("ready moved unasked");
endmodule

// ---- testbench/drive_model.sv ----
// command-pulse counter standing in for the motor drive
`timescale 1ns/1ps
module drive_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command pulses
  input wire logic [1:0] cmd_pulse,
  input wire logic [1:0] cmd_dir,
  // totals per axis
  output int cnt [2],
  output int gap [2],
  output int pos [2]
);
  int since [2];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '{0, 0};
      gap <= '{0, 0};
      pos <= '{0, 0};
      since <= '{0, 0};
    end else begin
      foreach (since[i]) begin
        since[i] <= cmd_pulse[i] ? 1 : since[i] + 1;
        if (cmd_pulse[i]) begin
          cnt[i] <= cnt[i] + 1;
          gap[i] <= since[i];
          pos[i] <= cmd_dir[i] ? pos[i] - 1 : pos[i] + 1;
        end
      end
    end
  end
endmodule

// ---- testbench/tb_top.sv ----
// bench for the home shift and backlash block
`timescale 1ns/1ps
`include "origin_shift_map.svh"
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
  logic controller_ready_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] homing_start, dog_on, zero_hit, move_pulse, move_dir;
  logic [1:0] cmd_pulse, cmd_dir;
  int cnt [2], gap [2], pos [2];
  int n_errors, compares;
  origin_shift_backlash_comp origin_shift_backlash_comp_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .homing_start(homing_start),
    .dog_on(dog_on), .zero_hit(zero_hit), .move_pulse(move_pulse),
    .move_dir(move_dir), .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir),
    .controller_ready_out(controller_ready_out));
  drive_model drive_model_inst (.pclk(pclk), .presetn(presetn),
    .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir), .cnt(cnt), .gap(gap),
    .pos(pos));
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  task report_and_stop;
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer; held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    re = pslverr;
    psel <= 0;
    penable <= 0;
    // idle edge so the next call never re-drives psel in this time step
    @(posedge pclk);
    if (k == 50) begin
      n_errors++;
      report_and_stop;
    end
  endtask
  task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(nm, e, rd);
  endtask
  // s: 0 start, 1 dog, 2 zero, 3 move
  task ev(input int s, input int ax, input logic d);
    logic [1:0] m;
    m = 2'b01 << ax;
    case (s)
      0: homing_start <= m;
      1: dog_on <= m;
      2: zero_hit <= m;
      default: begin
        move_pulse <= m;
        move_dir[ax] <= d;
      end
    endcase
    @(posedge pclk);
    {homing_start, dog_on, zero_hit, move_pulse} <= 8'h00;
    repeat (2) @(posedge pclk);
  endtask
  task home(input int ax);
    int k;
    ev(0, ax, 0);
    ev(1, ax, 0);
    repeat (3) ev(3, ax, 0);
    ev(2, ax, 0);
    k = 0;
    do begin
      apb(0, 12'(ax * 64) + `AX_STATUS_WORD, 0);
      k++;
    end while (rd[`ST_DONE_BIT] !== 1'b1 && k < 100);
    if (k == 100) begin
      n_errors++;
      report_and_stop;
    end
  endtask
  // parameters load only on a rising ready bit
  task ready;
    apb(1, `GLOBAL_CTRL, 0);
    apb(1, `GLOBAL_CTRL, 1);
    repeat (40) @(posedge pclk);
  endtask
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 0;
    pwdata = 0;
    {homing_start, dog_on, zero_hit, move_pulse, move_dir} = 10'h000;
    n_errors = 0;
    compares = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rchk("dist", `AX_SHIFT_DIST, 0);
    rchk("cfg1", 12'h40 + `AX_CFG, 0);
    rchk("bl", `AX_BACKLASH, 0);
    rchk("st", `AX_STATUS_WORD, 32'h8);
    apb(0, 12'h03c, 0);
    chk("slverr", 1, re);
    apb(1, `AX_SHIFT_DIST, 3);
    apb(1, `AX_HOMING_SPEED, 4);
    apb(1, 12'h40 + `AX_SHIFT_DIST, -2);
    apb(1, 12'h40 + `AX_CFG, 32'h11);
    apb(1, 12'h40 + `AX_CREEP_SPEED, 6);
    ready;
    chk("rdy", 1, controller_ready_out);
    home(0);
    chk("cnt0", 6, cnt[0]);
    chk("gap0", 4, gap[0]);
    chk("st0", 32'h10, rd);
    rchk("tad0", `AX_TRAVEL_DOG, 3);
    rchk("feed0", `AX_CUR_FEED, 0);
    rchk("op0", `AX_OP_STATUS, 0);
    home(1);
    chk("cnt1", 5, cnt[1]);
    chk("gap1", 6, gap[1]);
    chk("pos1", 1, pos[1]);
    rchk("tad1", 12'h40 + `AX_TRAVEL_DOG, 0);
    apb(1, `AX_SHIFT_DIST, 7);
    home(0);
    chk("cnt0b", 12, cnt[0]);
    apb(1, `AX_BACKLASH, 7);
    apb(1, `AX_GEAR, 32'h0002_0001);
    apb(1, 12'h40 + `AX_BACKLASH, 600);
    apb(1, 12'h40 + `AX_GEAR, 32'h0002_0001);
    ready;
    rchk("blp0", `AX_BL_PULSES, 3);
    rchk("err1", 12'h40 + `AX_ERR_CODE, 920);
    rchk("st1", 12'h40 + `AX_STATUS_WORD, 32'h11);
    ev(3, 0, 0);
    ev(3, 0, 1);
    repeat (20) @(posedge pclk);
    chk("cnt0c", 17, cnt[0]);
    chk("pos0", 9, pos[0]);
    rchk("cur0", `AX_CUR_FEED, 0);
    rchk("mach0", `AX_MACH_FEED, 0);
    ev(3, 1, 0);
    ev(3, 1, 1);
    apb(1, `AX_UNIT_MULT, 1);
    apb(1, `AX_GEAR, 32'h0002_0014);
    apb(1, 12'h40 + `AX_CFG, 32'h111);
    apb(1, 12'h40 + `AX_BACKLASH, 7);
    ready;
    rchk("blp0b", `AX_BL_PULSES, 7);
    ev(3, 1, 0);
    ev(3, 1, 1);
    repeat (20) @(posedge pclk);
    chk("cnt1b", 9, cnt[1]);
    apb(1, `AX_HOMING_REQ, 1);
    rchk("req0", `AX_STATUS_WORD, 32'h18);
    report_and_stop;
  end
endmodule
bind origin_shift_backlash_comp origin_shift_asserts origin_shift_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .homing_start(homing_start),
  .dog_on(dog_on), .zero_hit(zero_hit), .move_pulse(move_pulse),
  .move_dir(move_dir), .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir),
  .controller_ready_out(controller_ready_out));
